// ==== bsd_map.svh ====
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH
// oversampling ratio (reference configuration)
`define BSD_OSR 256
// width of integrators, delay registers and output word
`define BSD_ACC_W 24
// width of the decimation counter
`define BSD_DEC_CNT_W 8
// core clock period in ns
`define BSD_CORE_PERIOD_NS 50
// modulator clock half period in core clocks (20 MHz core / 2 = 10 MHz link)
`define BSD_MCLK_HALF 1
// ones density thresholds in 1/1000 units
`define BSD_DENS_ZERO 500
`define BSD_DENS_POS_FS 781
`define BSD_DENS_NEG_FS 219
`define BSD_DENS_FULL 1000
// input scale in microvolts
`define BSD_LIN_UV 250000
`define BSD_CLIP_UV 320000
`endif

// ==== bsd_pkg.sv ====
package bsd_pkg;
  `include "bsd_map.svh"
  typedef logic [`BSD_ACC_W-1:0]     bsd_acc_t;   // filter word
  typedef logic [`BSD_DEC_CNT_W-1:0] bsd_dcnt_t;  // decimation count
  typedef logic signed [19:0]        bsd_uv_t;    // input in microvolts
  typedef enum logic [1:0] {BSD_NEG_CLIP, BSD_LINEAR, BSD_POS_CLIP} bsd_range_e;
endpackage

// ==== bsd_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// link between modulator and filter
interface bsd_link_if;
  logic modulatorClockIn;  // modulator clock, made by the filter end
  logic bitstreamIn;       // one-bit density stream from the modulator
  modport modulator (input modulatorClockIn, output bitstreamIn);
  modport filter (output modulatorClockIn, input bitstreamIn);
endinterface
`default_nettype wire

// ==== bsd_modulator.sv ====
`timescale 1ns/100ps
`default_nettype none
// behavioural modulator end: first-order error feedback on a density target
module bsd_modulator
  import bsd_pkg::*;
(
  input  wire logic          core_clk,   // system clock
  input  wire logic          arst_n,     // async reset, active low
  input  wire logic          clkEn,      // clock enable
  input  wire bsd_uv_t       inputUv,    // differential input, microvolts
  bsd_link_if.modulator      link        // link side
);
  logic [10:0] accum_reg;     // density accumulator, 0..999
  logic        bit_reg;       // output bit
  logic [10:0] density;       // target ones per thousand
  logic signed [31:0] scaled; // linear density offset
  bsd_range_e  range;         // input region

  // classify input and map to ones density
  always_comb
  begin
    scaled = (32'(inputUv) * 281) / `BSD_LIN_UV;
    if (inputUv >= bsd_uv_t'(`BSD_CLIP_UV))
    begin
      range   = BSD_POS_CLIP;
      density = 11'(`BSD_DENS_FULL);
    end
    else if (inputUv <= -bsd_uv_t'(`BSD_CLIP_UV))
    begin
      range   = BSD_NEG_CLIP;
      density = 11'h000;
    end
    else
    begin
      range = BSD_LINEAR;
      // proportional, 500 at zero, 781/219 at full linear input
      density = 11'(32'(`BSD_DENS_ZERO) + scaled);
      if (density > 11'(`BSD_DENS_FULL))
        density = 11'(`BSD_DENS_FULL);
    end
  end

  // step once per link clock falling edge
  // link clock high now: this core edge is the one that lowers it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      accum_reg <= 11'h000;
      bit_reg   <= 1'b0;
    end
    else if (clkEn)
    begin
      if (link.modulatorClockIn)
      begin
        if (accum_reg + density >= 11'(`BSD_DENS_FULL))
        begin
          accum_reg <= 11'(accum_reg + density - 11'(`BSD_DENS_FULL));
          bit_reg   <= 1'b1;
        end
        else
        begin
          accum_reg <= 11'(accum_reg + density);
          bit_reg   <= 1'b0;
        end
      end
    end
  end

  assign link.bitstreamIn = bit_reg;
endmodule
`default_nettype wire

// ==== bsd_sinc3_filter.sv ====
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - modulator gives one bit per clock, falling edge
// - link clock held between 5 and 22 MHz
// - zero input gives half ones
// - full linear input gives 78.1/21.9 percent
// - clipping input gives all ones or zeros
// - receiver low-pass filters and decimates stream
// - sinc3 built as integrators then differentiators
// - oversampling ratio 16 to 256, parameter; here fixed at 256 by the BSD_OSR macro and the 8-bit counter
// - reference: ratio 256, 16-bit words
// - word rate is link clock over ratio
// - output settled after three word periods
// - optional faster sinc2 times one-plus-delay; not built here, sinc3 only
// - count ones, integrate twice per link clock
// - strobe latches integrator, three differences follow
// - 24-bit unsigned wrap-around arithmetic
// - reset clears counter, integrators, delays
module bsd_sinc3_filter
  import bsd_pkg::*;
(
  input  wire logic       core_clk,        // system clock
  input  wire logic       arst_n,          // async reset, active low
  input  wire logic       clkEn,           // clock enable
  input  wire logic       filterReset_n,   // filter reset, active low
  output logic            decimationStrobe,// one-cycle word strobe
  output var bsd_acc_t    filterOutputWord,// 24-bit sinc3 word
  output logic [15:0]     outputWord16,    // top 16 bits of word
  output logic            wordSettled,     // three words since reset
  bsd_link_if.filter      link             // link side
);
  logic      mclk_reg;           // link clock, divided from core
  bsd_acc_t  onesCounter;        // running count of ones
  bsd_acc_t  firstIntegrator;    // first integrator
  bsd_acc_t  secondIntegrator;   // second integrator
  bsd_acc_t  latchedIntegrator;  // strobe-latched integrator
  bsd_acc_t  firstDiffDelay;     // previous latched sample
  bsd_acc_t  secondDiffDelay;    // previous first difference
  bsd_acc_t  thirdDiffDelay;     // previous second difference
  bsd_acc_t  firstDifference;    // first comb
  bsd_acc_t  secondDifference;   // second comb
  bsd_acc_t  thirdDifference;    // third comb
  bsd_dcnt_t decCnt_reg;         // decimation counter
  logic      strobe_reg;         // strobe pulse
  logic      strobeDone_reg;     // strobe taken by combs
  logic [1:0] settleCnt_reg;     // words since reset
  logic      rst_n;              // combined reset
  logic      mclkRise;           // link clock rising edge

  // timing of one link clock, in core cycles:
  //   edge with mclk_reg low: link clock rises, filter samples the bit
  //   edge with mclk_reg high: link clock falls, modulator moves the bit
  // so the bit has stood a whole core cycle when it is sampled
  // filter reset is asynchronous, but the link clock keeps running
  // through it, so the modulator end is never stalled by it
  // clock enable low freezes every register of this end
  // all sums wrap; the combs cancel the wrap of the integrators

  // either reset clears filter state; link clock follows arst_n only
  assign rst_n    = arst_n & filterReset_n;
  // the next core edge raises the link clock when it is low now
  assign mclkRise = ~mclk_reg;                // next edge is rising

  // link clock: core divided by two, 10 MHz
  // inside the allowed band, and free-running between words
  // so the modulator never sees a stopped clock
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mclk_reg <= 1'b0;
    else if (clkEn)
      mclk_reg <= ~mclk_reg;
  end
  assign link.modulatorClockIn = mclk_reg;

  // ones counter: running count of ones, cleared only by reset
  // the combs remove its growing offset, so its wrap is harmless
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      onesCounter <= '0;
    else if (clkEn && mclkRise && link.bitstreamIn)
      onesCounter <= onesCounter + 24'h000001;
  end

  // first integrator: adds the ones counter once per link clock
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      firstIntegrator <= '0;
    else if (clkEn && mclkRise)
      firstIntegrator <= firstIntegrator + onesCounter;
  end

  // second integrator: adds the first one's old value
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      secondIntegrator <= '0;
    else if (clkEn && mclkRise)
      secondIntegrator <= secondIntegrator + firstIntegrator;
  end

  // decimation counter: counts link rising edges
  // its 8-bit width gives the wrap at the ratio for free
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      decCnt_reg <= '0;
    else if (clkEn && mclkRise)
      decCnt_reg <= decCnt_reg + 8'h01;
  end

  // strobe: one core cycle, at the last link clock of each word
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      strobe_reg <= 1'b0;
    else if (clkEn)
      strobe_reg <= mclkRise && (decCnt_reg == 8'(`BSD_OSR - 1));
  end
  assign decimationStrobe = strobe_reg;

  // comb differences, each against its own previous sample
  // unsigned wrap makes the differences exact despite integrator wrap
  assign firstDifference  = latchedIntegrator - firstDiffDelay;
  assign secondDifference = firstDifference - secondDiffDelay;
  assign thirdDifference  = secondDifference - thirdDiffDelay;

  // delay chain on strobe
  // every stage takes the old value of the one before it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latchedIntegrator <= '0;
      firstDiffDelay    <= '0;  // previous latched sample
      secondDiffDelay   <= '0;  // previous first difference
      thirdDiffDelay    <= '0;  // previous second difference
    end
    else if (clkEn && strobe_reg)
    begin
      latchedIntegrator <= secondIntegrator;
      firstDiffDelay    <= latchedIntegrator;  // first comb delay
      secondDiffDelay   <= firstDifference;    // second comb delay
      thirdDiffDelay    <= secondDifference;   // third comb delay
    end
  end

  // marks the cycle after the delays have latched
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      strobeDone_reg <= 1'b0;
    else if (clkEn)
      strobeDone_reg <= strobe_reg;
  end

  // full output word, held until the next word
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      filterOutputWord <= '0;
    else if (clkEn && strobeDone_reg)
      filterOutputWord <= thirdDifference;
  end

  // short word: top 16 bits, full scale 256^3 = 2^24
  // an all-ones stream wraps the full word, and so this one, to zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      outputWord16 <= 16'h0000;
    else if (clkEn && strobeDone_reg)
      outputWord16 <= thirdDifference[23:8];
  end

  // settle count: saturates at three words after any reset
  // users should ignore words while it is below three
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      settleCnt_reg <= 2'h0;
    else if (clkEn && strobeDone_reg && settleCnt_reg != 2'h3)
      settleCnt_reg <= settleCnt_reg + 2'h1;
  end
  assign wordSettled = (settleCnt_reg == 2'h3);
endmodule
`default_nettype wire

// ==== bsd_link_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// watches the link and the filter end's outputs
module bsd_link_chk
  import bsd_pkg::*;
(
  input wire logic        core_clk,         // system clock
  input wire logic        arst_n,           // async reset, active low
  input wire logic        filterReset_n,    // filter reset, active low
  input wire logic        modulatorClockIn, // link clock
  input wire logic        bitstreamIn,      // link data
  input wire logic        decimationStrobe, // word strobe
  input wire bsd_acc_t    filterOutputWord, // full word
  input wire logic [15:0] outputWord16,     // short word
  input wire logic        wordSettled       // settled flag
);
  logic [9:0] gapCnt;  // cycles since last strobe
  logic       seenStb; // a strobe seen since reset
  logic [1:0] wordCnt; // words since filter reset, saturating
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // strobe gap and word count, restarted by either reset
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gapCnt  <= '0;
      seenStb <= 1'b0;
      wordCnt <= '0;
    end
    else if (!filterReset_n || decimationStrobe)
    begin
      gapCnt  <= '0;
      seenStb <= filterReset_n;
      wordCnt <= !filterReset_n ? 2'h0 : (wordCnt == 2'h3) ? wordCnt : wordCnt + 2'h1;
    end
    else
      gapCnt <= gapCnt + 10'h1;
  end
  property p_mclk; 1'b1 |=> modulatorClockIn != $past(modulatorClockIn); endproperty
  a_mclk: assert property (p_mclk) else $error("link clock not toggling");
  property p_bit; $changed(bitstreamIn) |-> !modulatorClockIn && $past(modulatorClockIn); endproperty
  a_bit: assert property (p_bit) else $error("data moved off the falling edge");
  property p_gap; decimationStrobe && seenStb |-> gapCnt == 10'h1FF; endproperty
  a_gap: assert property (p_gap) else $error("word spacing wrong");
  property p_late; gapCnt < 10'h258; endproperty
  a_late: assert property (p_late) else $error("strobe missing");
  property p_pulse; decimationStrobe |=> !decimationStrobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_word; $changed(filterOutputWord) |-> !filterReset_n || $past(decimationStrobe, 2); endproperty
  a_word: assert property (p_word) else $error("word moved without strobe");
  property p_settle; $rose(wordSettled) |-> wordCnt == 2'h3; endproperty
  a_settle: assert property (p_settle) else $error("settled too early");
  property p_clear; !filterReset_n |-> !wordSettled && filterOutputWord == '0; endproperty
  a_clear: assert property (p_clear) else $error("filter reset not clearing");
  property p_short; outputWord16 == filterOutputWord[23:8]; endproperty
  a_short: assert property (p_short) else $error("short word not top bits");
endmodule
`default_nettype wire

// ==== bitstream_sinc3_decimator_test.sv ====
`timescale 1ns/100ps
`default_nettype none
// modulator and filter joined, graded at the filter's outputs and by ones counted on the link
module bitstream_sinc3_decimator_test
  import bsd_pkg::*;
;
  logic        core_clk, arst_n, clkEn, filterReset_n; // clock, resets, enable
  bsd_uv_t     inputUv;          // modulator input
  logic        decimationStrobe; // word strobe
  bsd_acc_t    filterOutputWord; // full word
  logic [15:0] outputWord16;     // short word
  logic        wordSettled;      // settled flag
  int          nErrors, totalChecks; // tallies
  bsd_link_if  link();           // link between the ends
  bsd_modulator i_bsd_modulator (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .inputUv(inputUv),
    .link(link.modulator));
  bsd_sinc3_filter i_bsd_sinc3_filter (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
    .filterReset_n(filterReset_n), .decimationStrobe(decimationStrobe), .filterOutputWord(filterOutputWord),
    .outputWord16(outputWord16), .wordSettled(wordSettled), .link(link.filter));
  bsd_link_chk i_bsd_link_chk (.core_clk(core_clk), .arst_n(arst_n), .filterReset_n(filterReset_n),
    .modulatorClockIn(link.modulatorClockIn), .bitstreamIn(link.bitstreamIn),
    .decimationStrobe(decimationStrobe), .filterOutputWord(filterOutputWord),
    .outputWord16(outputWord16), .wordSettled(wordSettled));
  // 20 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // waits for n words, then lets the last one land
  task automatic wait_words(input int n);
    int t;
    t = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      while (decimationStrobe !== 1'b1 && t < 9000)
      begin
        @(negedge core_clk);
        t++;
      end
    end
    repeat (3) @(negedge core_clk);
  endtask
  // applies an input, settles, grades the word against a ones density in 1/1000
  task automatic measure(input bsd_uv_t uv, input int dens, output logic ok);
    longint e;
    @(posedge core_clk);
    inputUv <= uv;
    wait_words(4);
    e = (longint'(dens) << 24) / 1000;
    ok = (filterOutputWord > e - 131072) && (filterOutputWord < e + 131072);
  endtask
  // ones seen over one word's worth of link clocks
  task automatic count_ones(output int ones);
    ones = 0;
    repeat (512)
    begin
      @(negedge core_clk);
      if (link.modulatorClockIn === 1'b1 && link.bitstreamIn === 1'b1)
        ones++;
    end
  endtask
  task automatic test_zero();
    logic ok;
    measure(20'h0, 500, ok);
    check(24'(ok), 24'h1);
    $display("test_zero done");
  endtask
  task automatic test_full();
    logic ok;
    measure(20'h3D090, 781, ok);
    check(24'(ok), 24'h1);
    measure(-20'sh3D090, 219, ok);
    check(24'(ok), 24'h1);
    $display("test_full done");
  endtask
  // filter reset mid-run, then settling count from scratch
  task automatic test_reset();
    @(posedge core_clk);
    filterReset_n <= 1'b0;
    repeat (3) @(negedge core_clk);
    check(filterOutputWord, 24'h0);
    check(24'(wordSettled), 24'h0);
    @(posedge core_clk);
    filterReset_n <= 1'b1;
    wait_words(2);
    check(24'(wordSettled), 24'h0);
    wait_words(1);
    check(24'(wordSettled), 24'h1);
    $display("test_reset done");
  endtask
  task automatic test_clip();
    int ones;
    @(posedge core_clk);
    inputUv <= 20'h4E200;
    wait_words(4);
    count_ones(ones);
    check(24'(ones), 24'h100);
    check(filterOutputWord, 24'h0);
    @(posedge core_clk);
    inputUv <= -20'sh4E200;
    wait_words(4);
    count_ones(ones);
    check(24'(ones), 24'h0);
    $display("test_clip done");
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    filterReset_n = 1'b1;
    inputUv = 20'h0;
    nErrors = 0;
    totalChecks = 0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    test_zero();
    test_full();
    test_reset();
    test_clip();
    giveVerdict();
  end
  // cuts a hung run short
  initial
  begin
    repeat (40000) @(posedge core_clk);
    nErrors++;
    giveVerdict();
  end
endmodule
`default_nettype wire
